/* File: hw/apf_pkg.sv */
/*
 package for the amplifier protection and fault logic: configurations,
 threshold-select decoding, half-bridge masks and timing constants.
 assumes the threshold setting arrives as a 4-bit resistor-range code.
*/
package apf_pkg;
  localparam int unsigned APF_NUM_HB = 4;
  localparam int unsigned APF_HB_A = 0;
  localparam int unsigned APF_HB_B = 1;
  localparam int unsigned APF_HB_C = 2;
  localparam int unsigned APF_HB_D = 3;
  localparam logic [3:0] APF_MASK_AB = 4'h3;
  localparam logic [3:0] APF_MASK_AD = 4'h9;
  localparam logic [3:0] APF_MASK_CD = 4'hc;
  localparam logic [3:0] APF_MASK_ALL = 4'hf;
  localparam logic [3:0] APF_MASK_NONE = 4'h0;
  localparam int unsigned APF_OLC_WIDTH = 6;
  localparam int unsigned APF_OLC_MAX = 63;
  localparam int unsigned APF_WARN_DEG_C = 125;
  localparam int unsigned APF_SEL_WIDTH = 4;
  localparam logic [1:0] APF_LEVEL_MIN = 2'h3;

  typedef enum logic [1:0] {
    APF_CFG_BRIDGE_TIED,
    APF_CFG_PARALLEL_BRIDGE,
    APF_CFG_SINGLE_ENDED,
    APF_CFG_RESERVED
  } apf_cfg_e;

  // threshold_select codes: resistor steps 22k,24k,27k,30k,47k,51k,56k,64k
  typedef enum logic [3:0] {
    APF_SEL_22K = 4'h0,
    APF_SEL_24K = 4'h1,
    APF_SEL_27K = 4'h2,
    APF_SEL_30K = 4'h3,
    APF_SEL_47K = 4'h4,
    APF_SEL_51K = 4'h5,
    APF_SEL_56K = 4'h6,
    APF_SEL_64K = 4'h7
  } apf_sel_e;

  typedef struct packed {
    logic cycle_mode;
    logic [1:0] level;
  } apf_oc_cfg_s;

  typedef struct packed {
    logic [3:0] overcurrent;
    logic [3:0] local_error;
    logic [3:0] boot_uv;
    logic undervoltage;
    logic over_warn;
    logic over_shutdown;
  } apf_det_s;

  function automatic apf_oc_cfg_s apf_decode_sel(input logic [3:0] sel);
    apf_oc_cfg_s r;
    r.cycle_mode = 1'b0;
    r.level = APF_LEVEL_MIN;
    if (sel <= 4'h7) begin
      r.cycle_mode = ~sel[2];
      r.level = sel[1:0];
    end
    return r;
  endfunction

  function automatic logic [3:0] apf_map_error(input logic [1:0] cfg, input logic [3:0] err);
    logic [3:0] m;
    m = APF_MASK_NONE;
    unique case (cfg)
      APF_CFG_BRIDGE_TIED: begin
        if (err[APF_HB_A]) m = m | APF_MASK_AB;
        if (err[APF_HB_B]) m = m | APF_MASK_AD;
        if (err[APF_HB_C] | err[APF_HB_D]) m = m | APF_MASK_CD;
      end
      APF_CFG_PARALLEL_BRIDGE: begin
        if (|err) m = APF_MASK_ALL;
      end
      default: begin
        if (err[APF_HB_A] | err[APF_HB_B]) m = m | APF_MASK_AB;
        if (err[APF_HB_C] | err[APF_HB_D]) m = m | APF_MASK_CD;
      end
    endcase
    return m;
  endfunction
endpackage

/* File: hw/apf_sync.sv */
/*
 two-flop synchroniser bank for asynchronous detector inputs.
 assumes inputs are levels held for at least two clocks.
*/
`timescale 1ns/1ps
module apf_sync import apf_pkg::*; #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] async_i,
  input wire logic [WIDTH-1:0] rst_val_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  // reset value comes in as a constant tie from the parent
  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_r <= rst_val_i;
      sync_r <= rst_val_i;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;
endmodule // apf_sync

/* File: hw/apf_olc.sv */
/*
 per half-bridge overload counter for cycle-by-cycle limiting.
 assumes frame_i is a one-cycle pulse at each pwm frame start.
*/
`timescale 1ns/1ps
module apf_olc import apf_pkg::*; #(
  parameter int unsigned WIDTH = APF_OLC_WIDTH,
  parameter int unsigned MAX = APF_OLC_MAX
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic enable_i,
  input wire logic oc_event_i,
  input wire logic frame_i,
  output logic at_max_o
);
  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;
  logic seen_r;
  logic seen_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    seen_nxt = seen_r;
    if (enable_i && oc_event_i && cnt_r != WIDTH'(MAX)) begin
      cnt_nxt = cnt_r + WIDTH'(1);
    end
    if (enable_i && oc_event_i) begin
      seen_nxt = 1'b1;
    end
    if (frame_i) begin
      // an event on the frame edge belongs to the new frame, so set wins
      seen_nxt = enable_i && oc_event_i;
      if (!seen_r && !oc_event_i && cnt_r != '0) begin
        cnt_nxt = cnt_r - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_r <= '0;
      seen_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      seen_r <= seen_nxt;
    end
  end

  assign at_max_o = (cnt_r == WIDTH'(MAX));

  a_cnt_bounded: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cnt_r <= WIDTH'(MAX))
    else $error("overload count above max");
  a_cnt_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (enable_i && oc_event_i && !frame_i && !at_max_o) |=> cnt_r == $past(cnt_r) + WIDTH'(1))
    else $error("overload count did not step");
  a_cnt_down: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (frame_i && !seen_r && !oc_event_i && cnt_r != '0) |=> cnt_r == $past(cnt_r) - WIDTH'(1))
    else $error("overload count did not drop");
  a_cnt_floor: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (frame_i && !seen_r && !oc_event_i && cnt_r == '0) |=> cnt_r == '0)
    else $error("overload count went below zero");
endmodule // apf_olc

/* File: hw/apf_top.sv */
/*
 protection and fault logic for a four half-bridge class-d power stage.
 assumes analog comparators give levels on pins, frame pulse is on clk_i.
*/
`timescale 1ns/1ps
module apf_top import apf_pkg::*; #(
  parameter int unsigned OLC_WIDTH = APF_OLC_WIDTH,
  parameter int unsigned OLC_MAX = APF_OLC_MAX
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic frame_i,
  input wire logic [1:0] config_i,
  input wire logic [APF_SEL_WIDTH-1:0] threshold_select_i,
  input wire logic [3:0] overcurrent_i,
  input wire logic [3:0] local_error_i,
  input wire logic [3:0] boot_uv_i,
  input wire logic undervoltage_lockout_i,
  input wire logic over_warn_i,
  input wire logic thermal_shutdown_i,
  output logic [3:0] hb_hiz_o,
  output logic [3:0] hb_flip_o,
  output logic [3:0] hb_high_off_o,
  output logic [1:0] oc_level_o,
  output logic cycle_current_limit_o,
  output logic fault_n_o,
  output logic fault_n_oe_o,
  output logic temp_warning_n_o,
  output logic temp_warning_n_oe_o
);
  localparam int unsigned DET_W = $bits(apf_det_s);
  localparam int unsigned STRAP_W = 2 + APF_SEL_WIDTH;

  apf_det_s det_raw;
  apf_det_s det;
  apf_oc_cfg_s oc_cfg;
  logic [3:0] olc_max;
  logic [3:0] oc_latch_set;
  logic [3:0] err_mask;
  logic [3:0] latched_mask;
  logic global_fault;
  logic any_shutdown;
  logic [STRAP_W-1:0] strap_sync;
  logic [1:0] out_cfg;
  logic [APF_SEL_WIDTH-1:0] sel_sync;

  logic [3:0] hb_latch_r;
  logic [3:0] hb_latch_nxt;
  logic therm_latch_r;
  logic therm_latch_nxt;
  logic [3:0] flip_r;
  logic [3:0] flip_nxt;
  logic [3:0] hiz_r;
  logic [3:0] hiz_nxt;
  logic [3:0] high_off_r;
  logic [3:0] high_off_nxt;
  logic fault_r;
  logic fault_nxt;
  logic warn_r;
  logic warn_nxt;
  apf_oc_cfg_s cfg_r;
  apf_oc_cfg_s cfg_nxt;

  assign det_raw.overcurrent = overcurrent_i;
  assign det_raw.local_error = local_error_i;
  assign det_raw.boot_uv = boot_uv_i;
  assign det_raw.undervoltage = undervoltage_lockout_i;
  assign det_raw.over_warn = over_warn_i;
  assign det_raw.over_shutdown = thermal_shutdown_i;

  // comparator outputs are asynchronous to the pwm clock
  apf_sync #(
    .WIDTH(DET_W)
  ) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .async_i(det_raw),
    .rst_val_i({DET_W{1'b0}}),
    .sync_o(det)
  );

  // straps are static in use; syncing keeps a live change from tearing the decode
  // reset value decodes to latched mode at level 0, same as cfg_r in reset
  apf_sync #(
    .WIDTH(STRAP_W)
  ) u_strap_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .async_i({config_i, threshold_select_i}),
    .rst_val_i({APF_CFG_BRIDGE_TIED, APF_SEL_47K}),
    .sync_o(strap_sync)
  );

  assign out_cfg = strap_sync[STRAP_W-1:APF_SEL_WIDTH];
  assign sel_sync = strap_sync[APF_SEL_WIDTH-1:0];
  assign oc_cfg = apf_decode_sel(sel_sync);

  genvar g;
  generate
    for (g = 0; g < APF_NUM_HB; g++) begin : g_olc
      apf_olc #(
        .WIDTH(OLC_WIDTH),
        .MAX(OLC_MAX)
      ) u_olc (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .enable_i(cfg_r.cycle_mode),
        .oc_event_i(det.overcurrent[g]),
        .frame_i(frame_i),
        .at_max_o(olc_max[g])
      );
    end
  endgenerate

  // latched mode trips on first event, limiting mode when counter saturates
  always_comb begin
    oc_latch_set = cfg_r.cycle_mode ? olc_max : det.overcurrent;
  end

  always_comb begin
    cfg_nxt = oc_cfg;
    therm_latch_nxt = therm_latch_r | det.over_shutdown;
    hb_latch_nxt = hb_latch_r | oc_latch_set;
    global_fault = therm_latch_r | det.over_shutdown | det.undervoltage;
    // channel faults spread per output configuration
    latched_mask = apf_map_error(out_cfg, hb_latch_nxt);
    err_mask = apf_map_error(out_cfg, det.local_error) | latched_mask;
    any_shutdown = global_fault | (|err_mask);
    hiz_nxt = global_fault ? APF_MASK_ALL : err_mask;
    // bootstrap loss only turns off that high side, outside the mask
    high_off_nxt = det.boot_uv;
    flip_nxt = flip_r;
    if (cfg_r.cycle_mode) begin
      flip_nxt = flip_r | det.overcurrent;
    end
    if (frame_i) begin
      flip_nxt = cfg_r.cycle_mode ? det.overcurrent : APF_MASK_NONE;
    end
    fault_nxt = any_shutdown;
    warn_nxt = det.over_warn;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      hb_latch_r <= APF_MASK_NONE;
      therm_latch_r <= 1'b0;
      flip_r <= APF_MASK_NONE;
      hiz_r <= APF_MASK_NONE;
      high_off_r <= APF_MASK_NONE;
      fault_r <= 1'b0;
      warn_r <= 1'b0;
      cfg_r <= '0;
    end else begin
      hb_latch_r <= hb_latch_nxt;
      therm_latch_r <= therm_latch_nxt;
      flip_r <= flip_nxt;
      hiz_r <= hiz_nxt;
      high_off_r <= high_off_nxt;
      fault_r <= fault_nxt;
      warn_r <= warn_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  assign hb_hiz_o = hiz_r;
  assign hb_flip_o = flip_r;
  assign hb_high_off_o = high_off_r;
  assign oc_level_o = cfg_r.level;
  assign cycle_current_limit_o = cfg_r.cycle_mode;
  // open drain: level always 0, enable pulls the line
  assign fault_n_o = 1'b0;
  assign fault_n_oe_o = fault_r;
  assign temp_warning_n_o = 1'b0;
  assign temp_warning_n_oe_o = warn_r;

  // global faults and reset
  a_fault_reset: assert property (@(posedge clk_i)
    !rstn_i |=> !fault_n_oe_o)
    else $error("fault pulled during reset");
  a_uv_hiz: assert property (@(posedge clk_i) disable iff (!rstn_i)
    det.undervoltage |=> hb_hiz_o == APF_MASK_ALL && fault_n_oe_o)
    else $error("undervoltage not shut down");
  a_therm_latch: assert property (@(posedge clk_i) disable iff (!rstn_i)
    det.over_shutdown |=> ##1 fault_n_oe_o [*3])
    else $error("thermal shutdown not latched");
  a_therm_hiz: assert property (@(posedge clk_i) disable iff (!rstn_i)
    det.over_shutdown |=> hb_hiz_o == APF_MASK_ALL && fault_n_oe_o)
    else $error("thermal shutdown not applied");
  a_therm_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    therm_latch_r |=> hb_hiz_o == APF_MASK_ALL && fault_n_oe_o)
    else $error("thermal latch released early");

  // overcurrent handling
  a_latched_oc: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!cfg_r.cycle_mode && det.overcurrent[0] && out_cfg == APF_CFG_BRIDGE_TIED)
    |=> hb_hiz_o[0] && hb_hiz_o[1])
    else $error("latched overcurrent not applied");
  a_latched_first: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!cfg_r.cycle_mode && det.overcurrent != 4'h0)
    |=> (hb_latch_r & $past(det.overcurrent)) == $past(det.overcurrent))
    else $error("first overcurrent not latched");
  a_olc_trip: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (cfg_r.cycle_mode && olc_max != 4'h0) |=> (hb_latch_r & $past(olc_max)) == $past(olc_max))
    else $error("overload maximum not latched");
  a_latch_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (hb_latch_r != 4'h0) |=> hb_hiz_o != 4'h0 && fault_n_oe_o)
    else $error("latched channel released");
  a_flip_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (cfg_r.cycle_mode && det.overcurrent != 4'h0)
    |=> (hb_flip_o & $past(det.overcurrent)) == $past(det.overcurrent))
    else $error("flip not set");
  a_flip_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (frame_i && det.overcurrent == 4'h0) |=> hb_flip_o == 4'h0)
    else $error("flip not cleared");

  // warning, bootstrap and mapping
  a_warn_follow: assert property (@(posedge clk_i) disable iff (!rstn_i)
    det.over_warn |=> temp_warning_n_oe_o)
    else $error("warning not driven");
  a_warn_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !det.over_warn |=> !temp_warning_n_oe_o)
    else $error("warning without cause");
  a_boot_local: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (det.boot_uv != 4'h0 && !any_shutdown) |=> hb_high_off_o == $past(det.boot_uv) && !fault_n_oe_o)
    else $error("bootstrap undervoltage misreported");
  a_parallel_all: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (out_cfg == APF_CFG_PARALLEL_BRIDGE && det.local_error != 4'h0) |=> hb_hiz_o == APF_MASK_ALL)
    else $error("parallel mapping wrong");
  a_local_recover: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!global_fault && det.local_error == 4'h0 && latched_mask == 4'h0) |=> hb_hiz_o == 4'h0)
    else $error("local fault did not recover");

  // threshold select and fault reporting
  a_sel_limit: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (sel_sync == APF_SEL_24K) |=> cycle_current_limit_o && oc_level_o == 2'h1)
    else $error("limiting select decoded wrong");
  a_sel_latched: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (sel_sync == APF_SEL_56K) |=> !cycle_current_limit_o && oc_level_o == 2'h2)
    else $error("latched select decoded wrong");
  a_bad_select: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sel_sync > 4'h7 |=> oc_level_o == APF_LEVEL_MIN && !cycle_current_limit_o)
    else $error("invalid select not at minimum");
  a_fault_code: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!global_fault && err_mask == 4'h0) |=> !fault_n_oe_o)
    else $error("fault without cause");
  a_fault_any: assert property (@(posedge clk_i) disable iff (!rstn_i)
    any_shutdown |=> fault_n_oe_o)
    else $error("shutdown without fault");

  c_uv: cover property (@(posedge clk_i) disable iff (!rstn_i) det.undervoltage ##1 !det.undervoltage);
  c_olc_trip: cover property (@(posedge clk_i) disable iff (!rstn_i) cfg_r.cycle_mode && |olc_max);
  c_therm: cover property (@(posedge clk_i) disable iff (!rstn_i) therm_latch_r);
  c_flip: cover property (@(posedge clk_i) disable iff (!rstn_i) |hb_flip_o);
  c_latched: cover property (@(posedge clk_i) disable iff (!rstn_i) !cfg_r.cycle_mode && |hb_latch_r);
endmodule // apf_top

/* File: bench/apf_ctrl_model.sv */
/*
 system controller model on the fault and warning lines.
 assumes open-drain pins with a pull-up on each line.
*/
`timescale 1ns/1ps
module apf_ctrl_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic fault_n_i,
  input wire logic fault_n_oe_i,
  input wire logic temp_warning_n_i,
  input wire logic temp_warning_n_oe_i,
  output logic fault_line_o,
  output logic warn_line_o,
  output logic warn_seen_o
);
  // pull-up wins whenever the device lets go
  assign fault_line_o = fault_n_oe_i ? fault_n_i : 1'b1;
  assign warn_line_o = temp_warning_n_oe_i ? temp_warning_n_i : 1'b1;
  // sticky, a real controller would turn volume down here
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      warn_seen_o <= 1'b0;
    end else if (!warn_line_o) begin
      warn_seen_o <= 1'b1;
    end
  end
endmodule // apf_ctrl_model

/* File: bench/apf_top_tb_top.sv */
/*
 self-checking bench for the protection and fault logic.
 assumes 3-edge pin-to-output latency and a small overload maximum.
*/
`timescale 1ns/1ps
module apf_top_tb_top;
  import apf_pkg::*;
  localparam int unsigned OLC_MAX_SIM = 3;
  localparam logic [3:0] MAP [4][4] = '{'{4'h3, 4'h9, 4'hc, 4'hc}, '{4'hf, 4'hf, 4'hf, 4'hf},
    '{4'h3, 4'h3, 4'hc, 4'hc}, '{4'h3, 4'h3, 4'hc, 4'hc}};
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic frame_i = 1'b0;
  logic [1:0] config_i = 2'h0;
  logic [3:0] sel = 4'h0;
  logic [3:0] oc = 4'h0;
  logic [3:0] lerr = 4'h0;
  logic [3:0] buv = 4'h0;
  logic uv = 1'b0;
  logic warn = 1'b0;
  logic hot = 1'b0;
  logic [3:0] hiz, flip, hoff;
  logic [1:0] lvl;
  logic ccl, f_n, f_oe, w_n, w_oe, f_line, w_line, w_seen;
  int num_errors = 0;
  int num_checks = 0;

  always #25 clk_i = ~clk_i;

  apf_top #(.OLC_MAX(OLC_MAX_SIM)) apf_top_inst (.clk_i(clk_i), .rstn_i(rstn_i), .frame_i(frame_i),
    .config_i(config_i), .threshold_select_i(sel), .overcurrent_i(oc), .local_error_i(lerr),
    .boot_uv_i(buv), .undervoltage_lockout_i(uv), .over_warn_i(warn), .thermal_shutdown_i(hot),
    .hb_hiz_o(hiz), .hb_flip_o(flip), .hb_high_off_o(hoff), .oc_level_o(lvl),
    .cycle_current_limit_o(ccl), .fault_n_o(f_n), .fault_n_oe_o(f_oe), .temp_warning_n_o(w_n),
    .temp_warning_n_oe_o(w_oe));
  apf_ctrl_model apf_ctrl_model_inst (.clk_i(clk_i), .rstn_i(rstn_i), .fault_n_i(f_n),
    .fault_n_oe_i(f_oe), .temp_warning_n_i(w_n), .temp_warning_n_oe_i(w_oe),
    .fault_line_o(f_line), .warn_line_o(w_line), .warn_seen_o(w_seen));

  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic do_reset();
    rstn_i = 1'b0;
    cyc(10);
    rstn_i = 1'b1;
    cyc(2);
  endtask
  task automatic frame();
    frame_i = 1'b1;
    cyc(1);
    frame_i = 1'b0;
    cyc(3);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic t_reset();
    hot = 1'b1;
    cyc(10);
    chk("fault line in reset", 4'h1, {3'h0, f_line});
    hot = 1'b0;
    rstn_i = 1'b1;
    cyc(4);
    chk("hiz after reset", 4'h0, hiz);
    chk("fault line after reset", 4'h1, {3'h0, f_line});
    $display("test reset done");
  endtask
  task automatic t_uv();
    uv = 1'b1;
    cyc(4);
    chk("hiz on uv", 4'hf, hiz);
    chk("fault line on uv", 4'h0, {3'h0, f_line});
    chk("warn line on uv", 4'h1, {3'h0, w_line});
    rstn_i = 1'b0;
    cyc(2);
    chk("fault line uv in reset", 4'h1, {3'h0, f_line});
    rstn_i = 1'b1;
    cyc(4);
    chk("fault line uv after reset", 4'h0, {3'h0, f_line});
    uv = 1'b0;
    cyc(4);
    chk("hiz after uv", 4'h0, hiz);
    chk("fault line after uv", 4'h1, {3'h0, f_line});
    $display("test undervoltage done");
  endtask
  task automatic t_warn();
    warn = 1'b1;
    cyc(4);
    chk("warn line hot", 4'h0, {3'h0, w_line});
    chk("fault line hot", 4'h1, {3'h0, f_line});
    chk("warn seen", 4'h1, {3'h0, w_seen});
    warn = 1'b0;
    cyc(4);
    chk("warn line cool", 4'h1, {3'h0, w_line});
    $display("test warning done");
  endtask
  task automatic t_thermal();
    hot = 1'b1;
    cyc(3);
    hot = 1'b0;
    cyc(4);
    chk("hiz thermal", 4'hf, hiz);
    chk("fault line thermal", 4'h0, {3'h0, f_line});
    do_reset();
    chk("hiz thermal cleared", 4'h0, hiz);
    chk("fault line cleared", 4'h1, {3'h0, f_line});
    $display("test thermal done");
  endtask
  task automatic t_map();
    for (int c = 0; c < 4; c++) begin
      for (int h = 0; h < 4; h++) begin
        config_i = c[1:0];
        lerr = 4'h1 << h;
        cyc(4);
        chk("hiz map", MAP[c][h], hiz);
        chk("fault line local", 4'h0, {3'h0, f_line});
        lerr = 4'h0;
        cyc(4);
        chk("hiz local cleared", 4'h0, hiz);
      end
    end
    config_i = 2'h0;
    $display("test mapping done");
  endtask
  task automatic t_boot();
    for (int h = 0; h < 4; h++) begin
      buv = 4'h1 << h;
      cyc(4);
      chk("high side off", 4'h1 << h, hoff);
      chk("hiz boot", 4'h0, hiz);
      chk("fault line boot", 4'h1, {3'h0, f_line});
      buv = 4'h0;
      cyc(4);
      chk("high side back", 4'h0, hoff);
    end
    $display("test bootstrap done");
  endtask
  task automatic t_sel();
    for (int s = 0; s < 16; s++) begin
      sel = s[3:0];
      cyc(3);
      chk("limit mode", {3'h0, s < 4}, {3'h0, ccl});
      chk("level", s < 8 ? {2'h0, sel[1:0]} : 4'h3, {2'h0, lvl});
    end
    $display("test threshold select done");
  endtask
  task automatic t_latched();
    sel = 4'h4;
    cyc(2);
    oc = 4'h1;
    cyc(1);
    oc = 4'h0;
    cyc(4);
    chk("hiz latched oc", 4'h3, hiz);
    chk("fault line oc", 4'h0, {3'h0, f_line});
    cyc(8);
    chk("hiz stays", 4'h3, hiz);
    do_reset();
    chk("hiz oc cleared", 4'h0, hiz);
    $display("test latched oc done");
  endtask
  task automatic pulse(input int n);
    oc = 4'h1;
    cyc(n);
    oc = 4'h0;
    cyc(4);
  endtask
  task automatic t_cycle();
    sel = 4'h0;
    cyc(2);
    pulse(1);
    chk("flip set", 4'h1, flip);
    chk("hiz while limiting", 4'h0, hiz);
    frame();
    chk("flip cleared", 4'h0, flip);
    repeat (2) frame();
    pulse(2);
    repeat (3) frame();
    pulse(2);
    chk("hiz after decrement", 4'h0, hiz);
    pulse(6);
    chk("hiz overload", 4'h3, hiz);
    chk("fault line overload", 4'h0, {3'h0, f_line});
    do_reset();
    chk("hiz overload cleared", 4'h0, hiz);
    $display("test cycle limit done");
  endtask

  initial begin
    cyc(20000);
    num_errors++;
    $display("wrong value run length expected finish seen timeout");
    end_sim();
  end
  initial begin
    t_reset();
    t_uv();
    t_warn();
    t_thermal();
    t_map();
    t_boot();
    t_sel();
    t_latched();
    t_cycle();
    end_sim();
  end
endmodule // apf_top_tb_top
